// ==== pkg/emcs_regs.svh ====
`ifndef EMCS_REGS_SVH
`define EMCS_REGS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define EMCS_IDX_STATUS 6'h05
`define EMCS_IDX_PHY 6'h06
`define EMCS_IDX_CTRL 6'h07
`define EMCS_IDX_TXST 6'h08
`define EMCS_IDX_TXLN 6'h0a
`define EMCS_IDX_RXST 6'h0c
`define EMCS_IDX_RXLN 6'h0e
`define EMCS_IDX_HTL 6'h10
`define EMCS_IDX_HTH 6'h14
`define EMCS_IDX_FILT 6'h18

// ****************************************
// Field positions
// ****************************************
`define EMCS_ST_CRC 5
`define EMCS_ST_NIB 4
`define EMCS_ST_MORE 3
`define EMCS_ST_BUSY 2
`define EMCS_ST_ABRT 1
`define EMCS_PHY_FIX_HI 3
`define EMCS_PHY_FIX_LO 1
`define EMCS_PHY_LOWPWR 0
`define EMCS_CT_TXRST 7
`define EMCS_CT_RXRST 6
`define EMCS_CT_GO 3
`define EMCS_CT_RXON 2
`define EMCS_FL_DEST 7
`define EMCS_FL_MODE 6
`define EMCS_FL_CRC 5
`define EMCS_FL_MAGIC 3
`define EMCS_FL_HASH 2
`define EMCS_FL_GROUP 1
`define EMCS_FL_BCAST 0

// ****************************************
// Reset values and constants
// ****************************************
`define EMCS_PHY_FIX_RST 3'h3
`define EMCS_HTL_RST 32'h484ea033
`define EMCS_HTH_RST 32'h5000ef97
`define EMCS_CRC_INIT 32'hffffffff
`define EMCS_CRC_POLY 32'hedb88320
`define EMCS_DEST_BYTES 16'h0006

`endif

// ==== pkg/emcs_pkg.sv ====
package emcs_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } emcs_wb_req_type;

  // Receive byte stream from the PHY side
  typedef struct packed {
    logic sof;
    logic valid;
    logic [7:0] data;
    logic eof;
    logic crc_bad;
    logic nibble_bad;
    logic oversize;
    logic magic;
  } emcs_rx_in_type;

  typedef enum logic [1:0] {
    EMCS_TX_IDLE,
    EMCS_TX_FETCH,
    EMCS_TX_SEND
  } emcs_tx_state_type;

  typedef enum logic {
    EMCS_RX_IDLE,
    EMCS_RX_FRAME
  } emcs_rx_state_type;

endpackage : emcs_pkg

// ==== design/emcs_top.sv ====
// Contract
// - Status bits 5,4,3 show CRC, nibble and oversize errors of receive.
// - Status bit 2 is high while a frame is being received.
// - Status bit 1 sets when software aborts a running transmission.
// - PHY bit 0 selects rated drive (0) or energy-saving drive (1).
// - Control bit 7 holds the transmit module in reset.
// - Control bit 6 holds the receive module in reset.
// - Writing 1 to control bit 3 starts transmit; hardware clears it.
// - Frames are accepted only while control bit 2 is 1.
// - Transmit start address is 16 bits, low 15 used, word aligned.
// - Receive start address is 16 bits, low 15 used, word aligned.
// - Transmit length says how many bytes are fetched from the buffer.
// - Receive length is read-only, resets to zero.
// - Filter bit 6 picks any-condition or all-conditions acceptance.
// - Filter bit 7 tests destination against the station address.
// - Filter bit 5 tests the frame CRC result.
// - Filter bit 3 tests for a magic packet.
// - Filter bit 2 tests the 64-bit hash table.
// - Filter bit 1 tests for a multicast destination.
// - Filter bit 0 in any-mode accepts broadcast frames.
// - Filter bit 0 in all-mode discards non-broadcast frames.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`include "emcs_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module emcs_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire emcs_pkg::emcs_wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [47:0] station_addr,
  input wire emcs_pkg::emcs_rx_in_type rx_in,
  output logic rx_dma_wr_valid,
  output logic [14:0] rx_dma_wr_addr,
  output logic [7:0] rx_dma_wr_data,
  output logic rx_frame_stored,
  output logic tx_dma_rd_req,
  output logic [14:0] tx_dma_rd_addr,
  input wire logic tx_dma_rd_ack,
  input wire logic [7:0] tx_dma_rd_data,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_byte_ready,
  output logic tx_frame_done,
  output logic tx_low_power_drive
);
  import emcs_pkg::*;

  // ****************************************
  // Functions
  // ****************************************

  // One byte of reflected CRC-32
  function automatic logic [31:0] emcs_crc_byte(input logic [31:0] c,
    input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `EMCS_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : emcs_crc_byte

  // Byte-lane merge of a write into a 32-bit register
  function automatic logic [31:0] emcs_merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : emcs_merge

  // ****************************************
  // Register bus and register file
  // ****************************************
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [2:0] phy_fix_reg, phy_fix_next;
  logic low_pwr_reg, low_pwr_next;
  logic tx_rst_reg, tx_rst_next;
  logic rx_rst_reg, rx_rst_next;
  logic tx_go_reg, tx_go_next;
  logic rx_on_reg, rx_on_next;
  logic [15:0] txst_reg, txst_next;
  logic [15:0] txln_reg, txln_next;
  logic [15:0] rxst_reg, rxst_next;
  logic [63:0] hash_reg, hash_next;
  logic [7:0] filt_reg, filt_next;
  logic abort_reg, abort_next;
  logic [7:0] status_rd;
  logic [7:0] ctrl_rd;
  logic [5:0] idx;
  logic wr_en;
  logic tx_finish;
  logic tx_busy;
  logic [15:0] rxln_reg;
  logic rx_busy;
  logic crc_err_reg, nib_err_reg, more_err_reg;

  assign idx = wb_req.adr[7:2];
  assign wr_en = wb_req.cyc & wb_req.stb & wb_req.we & ~ack_reg;

  // Read views of status and control
  always_comb begin
    status_rd = 8'h00;
    status_rd[`EMCS_ST_CRC] = crc_err_reg;
    status_rd[`EMCS_ST_NIB] = nib_err_reg;
    status_rd[`EMCS_ST_MORE] = more_err_reg;
    status_rd[`EMCS_ST_BUSY] = rx_busy;
    status_rd[`EMCS_ST_ABRT] = abort_reg;
    ctrl_rd = 8'h00;
    ctrl_rd[`EMCS_CT_TXRST] = tx_rst_reg;
    ctrl_rd[`EMCS_CT_RXRST] = rx_rst_reg;
    ctrl_rd[`EMCS_CT_GO] = tx_go_reg;
    ctrl_rd[`EMCS_CT_RXON] = rx_on_reg;
  end

  // Next values of bus answer and registers
  always_comb begin
    ack_next = wb_req.cyc & wb_req.stb & ~ack_reg;
    rdat_next = rdat_reg;
    phy_fix_next = phy_fix_reg;
    low_pwr_next = low_pwr_reg;
    tx_rst_next = tx_rst_reg;
    rx_rst_next = rx_rst_reg;
    tx_go_next = tx_go_reg;
    rx_on_next = rx_on_reg;
    txst_next = txst_reg;
    txln_next = txln_reg;
    rxst_next = rxst_reg;
    hash_next = hash_reg;
    filt_next = filt_reg;
    abort_next = abort_reg;
    if (tx_finish) begin
      tx_go_next = 1'b0;
    end
    if (ack_next) begin
      case (idx)
        `EMCS_IDX_STATUS: rdat_next = {24'h000000, status_rd};
        `EMCS_IDX_PHY: rdat_next = {28'h0000000, phy_fix_reg, low_pwr_reg};
        `EMCS_IDX_CTRL: rdat_next = {24'h000000, ctrl_rd};
        `EMCS_IDX_TXST: rdat_next = {16'h0000, txst_reg};
        `EMCS_IDX_TXLN: rdat_next = {16'h0000, txln_reg};
        `EMCS_IDX_RXST: rdat_next = {16'h0000, rxst_reg};
        `EMCS_IDX_RXLN: rdat_next = {16'h0000, rxln_reg};
        `EMCS_IDX_HTL: rdat_next = hash_reg[31:0];
        `EMCS_IDX_HTH: rdat_next = hash_reg[63:32];
        `EMCS_IDX_FILT: rdat_next = {24'h000000, filt_reg[7:5],
                                     1'b0, filt_reg[3:0]};
        default: rdat_next = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      case (idx)
        `EMCS_IDX_PHY: begin
          if (wb_req.sel[0]) begin
            phy_fix_next = wb_req.dat[`EMCS_PHY_FIX_HI:`EMCS_PHY_FIX_LO];
            low_pwr_next = wb_req.dat[`EMCS_PHY_LOWPWR];
          end
        end
        `EMCS_IDX_CTRL: begin
          if (wb_req.sel[0]) begin
            tx_rst_next = wb_req.dat[`EMCS_CT_TXRST];
            rx_rst_next = wb_req.dat[`EMCS_CT_RXRST];
            rx_on_next = wb_req.dat[`EMCS_CT_RXON];
            // write one starts, set beats clear
            if (wb_req.dat[`EMCS_CT_GO]) begin
              tx_go_next = 1'b1;
            end
            if (wb_req.dat[`EMCS_CT_TXRST] && tx_busy) begin
              abort_next = 1'b1;
            end
          end
        end
        `EMCS_IDX_TXST: txst_next = 16'(emcs_merge({16'h0000, txst_reg},
          wb_req.dat, wb_req.sel));
        `EMCS_IDX_TXLN: txln_next = 16'(emcs_merge({16'h0000, txln_reg},
          wb_req.dat, wb_req.sel));
        `EMCS_IDX_RXST: rxst_next = 16'(emcs_merge({16'h0000, rxst_reg},
          wb_req.dat, wb_req.sel));
        `EMCS_IDX_HTL: hash_next[31:0] = emcs_merge(hash_reg[31:0],
          wb_req.dat, wb_req.sel);
        `EMCS_IDX_HTH: hash_next[63:32] = emcs_merge(hash_reg[63:32],
          wb_req.dat, wb_req.sel);
        `EMCS_IDX_FILT: begin
          if (wb_req.sel[0]) begin
            filt_next = {wb_req.dat[7:5], 1'b0, wb_req.dat[3:0]};
          end
        end
        default: ;
      endcase
    end
    if (tx_rst_next) begin
      tx_go_next = 1'b0;
    end
    // a fresh start clears the abort mark
    if (!tx_go_reg && tx_go_next) begin
      abort_next = 1'b0;
    end
  end

  // Register the bus and register file
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
      phy_fix_reg <= `EMCS_PHY_FIX_RST;
      low_pwr_reg <= 1'b0;
      tx_rst_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
      tx_go_reg <= 1'b0;
      rx_on_reg <= 1'b0;
      txst_reg <= 16'h0000;
      txln_reg <= 16'h0000;
      rxst_reg <= 16'h0000;
      hash_reg <= {`EMCS_HTH_RST, `EMCS_HTL_RST};
      filt_reg <= 8'h00;
      abort_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      phy_fix_reg <= phy_fix_next;
      low_pwr_reg <= low_pwr_next;
      tx_rst_reg <= tx_rst_next;
      rx_rst_reg <= rx_rst_next;
      tx_go_reg <= tx_go_next;
      rx_on_reg <= rx_on_next;
      txst_reg <= txst_next;
      txln_reg <= txln_next;
      rxst_reg <= rxst_next;
      hash_reg <= hash_next;
      filt_reg <= filt_next;
      abort_reg <= abort_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign tx_low_power_drive = low_pwr_reg;

  // ****************************************
  // Transmit engine
  // ****************************************
  emcs_tx_state_type tx_state_reg, tx_state_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic tx_req_reg, tx_req_next;
  logic [14:0] tx_addr_reg, tx_addr_next;
  logic tx_val_reg, tx_val_next;
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic tx_done_reg, tx_done_next;

  assign tx_busy = (tx_state_reg != EMCS_TX_IDLE);
  assign tx_finish = tx_done_next;

  // Fetch one byte, send it, repeat for the length
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_req_next = tx_req_reg;
    tx_addr_next = tx_addr_reg;
    tx_val_next = tx_val_reg;
    tx_byte_next = tx_byte_reg;
    tx_done_next = 1'b0;
    case (tx_state_reg)
      EMCS_TX_IDLE: begin
        if (tx_go_reg && !tx_rst_reg) begin
          tx_cnt_next = 16'h0000;
          tx_addr_next = txst_reg[14:0];
          if (txln_reg == 16'h0000) begin
            tx_done_next = 1'b1;
          end else begin
            tx_req_next = 1'b1;
            tx_state_next = EMCS_TX_FETCH;
          end
        end
      end
      EMCS_TX_FETCH: begin
        if (tx_dma_rd_ack) begin
          tx_req_next = 1'b0;
          tx_val_next = 1'b1;
          tx_byte_next = tx_dma_rd_data;
          tx_state_next = EMCS_TX_SEND;
        end
      end
      EMCS_TX_SEND: begin
        if (tx_byte_ready) begin
          tx_val_next = 1'b0;
          tx_cnt_next = tx_cnt_reg + 16'h0001;
          tx_addr_next = tx_addr_reg + 15'h0001;
          if (tx_cnt_reg + 16'h0001 == txln_reg) begin
            tx_done_next = 1'b1;
            tx_state_next = EMCS_TX_IDLE;
          end else begin
            tx_req_next = 1'b1;
            tx_state_next = EMCS_TX_FETCH;
          end
        end
      end
      default: tx_state_next = EMCS_TX_IDLE;
    endcase
    if (tx_rst_reg) begin
      tx_state_next = EMCS_TX_IDLE;
      tx_req_next = 1'b0;
      tx_val_next = 1'b0;
      tx_done_next = 1'b0;
    end
  end

  // Register the transmit engine
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_state_reg <= EMCS_TX_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_req_reg <= 1'b0;
      tx_addr_reg <= 15'h0000;
      tx_val_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_done_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_req_reg <= tx_req_next;
      tx_addr_reg <= tx_addr_next;
      tx_val_reg <= tx_val_next;
      tx_byte_reg <= tx_byte_next;
      tx_done_reg <= tx_done_next;
    end
  end

  assign tx_dma_rd_req = tx_req_reg;
  assign tx_dma_rd_addr = tx_addr_reg;
  assign tx_byte_valid = tx_val_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_frame_done = tx_done_reg;

  // ****************************************
  // Receive engine and filter
  // ****************************************
  emcs_rx_state_type rx_state_reg, rx_state_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [15:0] rxln_next;
  logic [47:0] dest_reg, dest_next;
  logic [31:0] crc_reg, crc_next;
  logic crc_err_next, nib_err_next, more_err_next;
  logic wr_val_reg, wr_val_next;
  logic [14:0] wr_addr_reg, wr_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic stored_reg, stored_next;
  logic [5:0] hash_idx;
  logic [7:0] hit;
  logic accept;

  assign rx_busy = (rx_state_reg == EMCS_RX_FRAME);
  // six CRC bits select the table bit
  assign hash_idx = crc_reg[31:26];

  // Per-condition results, indexed like the filter bits
  always_comb begin
    hit = 8'h00;
    hit[`EMCS_FL_DEST] = (dest_reg == station_addr);
    hit[`EMCS_FL_CRC] = ~rx_in.crc_bad;
    hit[`EMCS_FL_MAGIC] = rx_in.magic;
    hit[`EMCS_FL_HASH] = hash_reg[hash_idx];
    hit[`EMCS_FL_GROUP] = dest_reg[40];
    hit[`EMCS_FL_BCAST] = &dest_reg;
  end

  always_comb begin
    if (filt_reg[`EMCS_FL_MODE]) begin
      accept = &(hit | ~filt_reg | 8'h40);
    end else if ((filt_reg & 8'hbf) == 8'h00) begin
      accept = 1'b1;
    end else begin
      accept = |(hit & filt_reg & 8'hbf);
    end
  end

  // Byte collection, buffer writes and frame end
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rxln_next = rxln_reg;
    dest_next = dest_reg;
    crc_next = crc_reg;
    crc_err_next = crc_err_reg;
    nib_err_next = nib_err_reg;
    more_err_next = more_err_reg;
    wr_val_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    stored_next = 1'b0;
    case (rx_state_reg)
      EMCS_RX_IDLE: begin
        // start only while reception is on
        if (rx_in.sof && rx_on_reg) begin
          rx_cnt_next = 16'h0000;
          dest_next = 48'h000000000000;
          crc_next = `EMCS_CRC_INIT;
          rx_state_next = EMCS_RX_FRAME;
        end
      end
      EMCS_RX_FRAME: begin
        if (rx_in.valid) begin
          wr_val_next = 1'b1;
          wr_addr_next = rxst_reg[14:0] + rx_cnt_reg[14:0];
          wr_data_next = rx_in.data;
          rx_cnt_next = rx_cnt_reg + 16'h0001;
          if (rx_cnt_reg < `EMCS_DEST_BYTES) begin
            dest_next = {dest_reg[39:0], rx_in.data};
            crc_next = emcs_crc_byte(crc_reg, rx_in.data);
          end
        end else if (rx_in.eof) begin
          // error flags of the finished frame
          crc_err_next = rx_in.crc_bad;
          nib_err_next = rx_in.nibble_bad;
          more_err_next = rx_in.oversize;
          if (accept) begin
            rxln_next = rx_cnt_reg;
            stored_next = 1'b1;
          end
          rx_state_next = EMCS_RX_IDLE;
        end
      end
      default: rx_state_next = EMCS_RX_IDLE;
    endcase
    if (rx_rst_reg) begin
      rx_state_next = EMCS_RX_IDLE;
      wr_val_next = 1'b0;
      stored_next = 1'b0;
    end
  end

  // Register the receive engine
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_state_reg <= EMCS_RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rxln_reg <= 16'h0000;
      dest_reg <= 48'h000000000000;
      crc_reg <= `EMCS_CRC_INIT;
      crc_err_reg <= 1'b0;
      nib_err_reg <= 1'b0;
      more_err_reg <= 1'b0;
      wr_val_reg <= 1'b0;
      wr_addr_reg <= 15'h0000;
      wr_data_reg <= 8'h00;
      stored_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rxln_reg <= rxln_next;
      dest_reg <= dest_next;
      crc_reg <= crc_next;
      crc_err_reg <= crc_err_next;
      nib_err_reg <= nib_err_next;
      more_err_reg <= more_err_next;
      wr_val_reg <= wr_val_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      stored_reg <= stored_next;
    end
  end

  assign rx_dma_wr_valid = wr_val_reg;
  assign rx_dma_wr_addr = wr_addr_reg;
  assign rx_dma_wr_data = wr_data_reg;
  assign rx_frame_stored = stored_reg;

endmodule : emcs_top

`default_nettype wire

// ==== test/emcs_chk.sv ====
`include "emcs_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker
// ********
module emcs_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire emcs_pkg::emcs_wb_req_type wb_req,
  input wire logic wb_ack_o,
  input wire logic tx_dma_rd_req,
  input wire logic [14:0] tx_dma_rd_addr,
  input wire logic tx_dma_rd_ack,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_ready,
  input wire logic tx_frame_done,
  input wire logic rx_dma_wr_valid,
  input wire logic rx_frame_stored,
  input wire logic tx_low_power_drive
);
  import emcs_pkg::*;
  logic take, wr_ctl, txr_reg, txr_next, rxr_reg, rxr_next, drv_reg, drv_next;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Mirror of reset and drive bits
  always_comb begin
    take = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack_o && wb_req.sel[0];
    wr_ctl = take && wb_req.adr[7:2] == `EMCS_IDX_CTRL;
    txr_next = wr_ctl ? wb_req.dat[`EMCS_CT_TXRST] : txr_reg;
    rxr_next = wr_ctl ? wb_req.dat[`EMCS_CT_RXRST] : rxr_reg;
    drv_next = drv_reg;
    if (take && wb_req.adr[7:2] == `EMCS_IDX_PHY) begin
      drv_next = wb_req.dat[`EMCS_PHY_LOWPWR];
    end
  end
  // Mirror registers
  always_ff @(posedge clk_sys) begin
    txr_reg <= srst ? 1'b0 : txr_next;
    rxr_reg <= srst ? 1'b0 : rxr_next;
    drv_reg <= srst ? 1'b0 : drv_next;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o
    |=> wb_ack_o) else $error("ack not one cycle after request");
  a_fetch_hold: assert property (
    tx_dma_rd_req && !tx_dma_rd_ack && !txr_reg && !wr_ctl
    |=> tx_dma_rd_req && $stable(tx_dma_rd_addr))
    else $error("fetch request dropped early");
  a_byte_hold: assert property (
    tx_byte_valid && !tx_byte_ready && !txr_reg && !wr_ctl
    |=> tx_byte_valid && $stable(tx_byte)) else $error("byte dropped early");
  a_tx_held: assert property (
    txr_reg |=> !tx_dma_rd_req && !tx_byte_valid)
    else $error("transmit active in reset");
  a_rx_held: assert property (
    rxr_reg |=> !rx_dma_wr_valid && !rx_frame_stored)
    else $error("receive active in reset");
  a_done_pulse: assert property (tx_frame_done |=> !tx_frame_done)
    else $error("done longer than one cycle");
  a_stored_pulse: assert property (rx_frame_stored |=> !rx_frame_stored)
    else $error("stored longer than one cycle");
  a_drive_level: assert property ($stable(drv_reg)
    |-> tx_low_power_drive == drv_reg) else $error("drive level wrong");
  c_done: cover property (tx_frame_done);
  c_stored: cover property (rx_frame_stored);
  c_stall: cover property (tx_byte_valid && !tx_byte_ready);
endmodule : emcs_chk
bind emcs_top emcs_chk u_chk (.clk_sys, .srst, .wb_req, .wb_ack_o,
  .tx_dma_rd_req, .tx_dma_rd_addr, .tx_dma_rd_ack, .tx_byte_valid, .tx_byte,
  .tx_byte_ready, .tx_frame_done, .rx_dma_wr_valid, .rx_frame_stored,
  .tx_low_power_drive);
`default_nettype wire

// ==== test/emcs_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Far side: buffer memory, line sink, frame source
// ********
module emcs_peer (
  input wire logic clk_sys,
  input wire logic tx_dma_rd_req,
  input wire logic [14:0] tx_dma_rd_addr,
  output logic tx_dma_rd_ack,
  output logic [7:0] tx_dma_rd_data,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_byte_ready,
  output var emcs_pkg::emcs_rx_in_type rx_in
);
  int seed = 10;
  int r;
  logic [7:0] got[$];
  // Idle outputs at time zero
  initial begin
    tx_dma_rd_ack = 1'b0;
    tx_dma_rd_data = 8'h00;
    tx_byte_ready = 1'b0;
    rx_in = '0;
  end
  // buffer byte per address, random stalls
  always @(posedge clk_sys) begin
    r = $random(seed);
    tx_byte_ready <= r[1];
    if (tx_byte_valid === 1'b1 && tx_byte_ready) got.push_back(tx_byte);
    if (tx_dma_rd_req === 1'b1 && !tx_dma_rd_ack && r[0]) begin
      tx_dma_rd_ack <= 1'b1;
      tx_dma_rd_data <= tx_dma_rd_addr[7:0] ^ 8'h3c;
    end else begin
      tx_dma_rd_ack <= 1'b0;
      tx_dma_rd_data <= ~tx_dma_rd_data;
    end
  end
  // One frame: start, spaced bytes, end with flags
  task automatic send_frame(input logic [7:0] b[$], input logic [3:0] fl);
    @(posedge clk_sys) rx_in <= {2'b10, ~rx_in.data, 5'h00};
    foreach (b[i]) begin
      @(posedge clk_sys) rx_in <= {2'b01, b[i], 5'h00};
      @(posedge clk_sys) rx_in <= {2'b00, ~b[i], 5'h00};
    end
    @(posedge clk_sys) rx_in <= {2'b00, ~rx_in.data, 1'b1, fl};
    @(posedge clk_sys) rx_in <= {2'b00, ~rx_in.data, 5'h00};
  endtask : send_frame
endmodule : emcs_peer
`default_nettype wire

// ==== test/testbench.sv ====
`include "emcs_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Testbench
// ********
module testbench;
  import emcs_pkg::*;
  logic clk_sys, srst, wb_ack_o, rx_dma_wr_valid, rx_frame_stored, acc, live;
  logic tx_dma_rd_req, tx_dma_rd_ack, tx_byte_valid, tx_byte_ready;
  logic tx_frame_done, tx_low_power_drive;
  logic [31:0] wb_dat_o, rd, ht, stat, last_len;
  logic [47:0] station_addr, dst;
  logic [14:0] rx_dma_wr_addr, tx_dma_rd_addr;
  logic [7:0] rx_dma_wr_data, tx_dma_rd_data, tx_byte, filt, ctl;
  logic [3:0] fl;
  logic [7:0] fr[$];
  emcs_wb_req_type wb_req;
  emcs_rx_in_type rx_in;
  int seed, n_mismatch, n_tests, n_stored, n_done, j, k, ln, st, n0;
  logic [5:0] ri[11] = '{`EMCS_IDX_STATUS, `EMCS_IDX_PHY, `EMCS_IDX_CTRL,
    `EMCS_IDX_TXST, `EMCS_IDX_TXLN, `EMCS_IDX_RXST, `EMCS_IDX_RXLN,
    `EMCS_IDX_HTL, `EMCS_IDX_HTH, `EMCS_IDX_FILT, 6'h3f};
  logic [31:0] rv[11] = '{0, 6, 0, 0, 0, 0, 0, `EMCS_HTL_RST, `EMCS_HTH_RST,
    0, 0};
  logic [31:0] rm[11] = '{0, 0, 0, 32'hffff, 32'hffff, 32'hffff, 0,
    32'hffffffff, 32'hffffffff, 32'hef, 0};
  logic [47:0] dests[4] = '{48'h02a1b2c3d4e5, 48'hffffffffffff,
    48'h01005e000001, 48'h0a0b0c0d0e0f};
  emcs_top u_dut (.clk_sys, .srst, .wb_req, .wb_dat_o, .wb_ack_o,
    .station_addr, .rx_in, .rx_dma_wr_valid, .rx_dma_wr_addr, .rx_dma_wr_data,
    .rx_frame_stored, .tx_dma_rd_req, .tx_dma_rd_addr, .tx_dma_rd_ack,
    .tx_dma_rd_data, .tx_byte_valid, .tx_byte, .tx_byte_ready, .tx_frame_done,
    .tx_low_power_drive);
  emcs_peer u_peer (.clk_sys, .tx_dma_rd_req, .tx_dma_rd_addr, .tx_dma_rd_ack,
    .tx_dma_rd_data, .tx_byte_valid, .tx_byte, .tx_byte_ready, .rx_in);
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Pulse counters
  always @(posedge clk_sys) begin
    if (rx_frame_stored === 1'b1) n_stored++;
    if (tx_frame_done === 1'b1) n_done++;
  end
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Classic bus cycle, held until ack sampled
  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [31:0] d, input logic [3:0] sel);
    int w;
    @(posedge clk_sys);
    wb_req <= {2'b11, we, idx, 2'b00, sel, d};
    for (w = 0; w < 20 && wb_ack_o !== 1'b1; w++) @(posedge clk_sys);
    rd = wb_dat_o;
    wb_req <= '0;
    if (w == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : wb
  task automatic rc(input logic [5:0] idx, input logic [31:0] e, string what);
    wb(1'b0, idx, 32'h0, 4'hf);
    check(what, rd, e);
  endtask : rc
  task automatic go_wait();
    int w;
    n0 = n_done;
    wb(1'b1, `EMCS_IDX_CTRL, 32'h08, 4'h1);
    for (w = 0; w < 600 && n_done == n0; w++) @(posedge clk_sys);
    if (w == 600) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : go_wait
  function automatic logic accept(logic [7:0] f, logic [47:0] d, logic h);
    logic [5:0] en, ok;
    en = {f[7], f[5], f[3], f[2], f[1], f[0]};
    ok = {d == station_addr, !fl[3], fl[0], h, d[40], &d};
    if (f[6]) return &(~en | ok);
    return en == 6'h0 || |(en & ok);
  endfunction : accept
  // Main sequence
  initial begin
    seed = 10;
    srst = 1'b1;
    wb_req = '0;
    station_addr = dests[0];
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    for (j = 0; j < 11; j++) rc(ri[j], rv[j], "reset");
    for (j = 0; j < 11; j++) begin
      if (j == 1 || j == 2) continue;
      ht = $random(seed) & 32'hfffffffc;
      wb(1'b1, ri[j], ht, 4'hf);
      rc(ri[j], ht & rm[j], "rw");
    end
    for (k = 0; k < 2; k++) begin
      wb(1'b1, `EMCS_IDX_PHY, 32'h6 | k, 4'h1);
      repeat (2) @(posedge clk_sys);
      check("drive", tx_low_power_drive, k);
    end
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      st = $random(seed) & 32'h7ffc;
      ln = (k == 0) ? 0 : 1 + ({$random(seed)} % 7);
      u_peer.got.delete();
      wb(1'b1, `EMCS_IDX_TXST, st, 4'h3);
      wb(1'b1, `EMCS_IDX_TXLN, ln, 4'h3);
      go_wait();
      check("tx count", u_peer.got.size(), ln);
      for (j = 0; j < ln; j++)
        check("tx byte", u_peer.got[j], 8'(st + j) ^ 8'h3c);
      rc(`EMCS_IDX_CTRL, 32'h0, "go self clear");
    end
    wb(1'b1, `EMCS_IDX_TXLN, 32'd40, 4'h3);
    wb(1'b1, `EMCS_IDX_CTRL, 32'h08, 4'h1);
    repeat (6) @(posedge clk_sys);
    wb(1'b1, `EMCS_IDX_CTRL, 32'h80, 4'h1);
    rc(`EMCS_IDX_STATUS, 32'h02, "tx aborted");
    rc(`EMCS_IDX_CTRL, 32'h80, "go dropped");
    wb(1'b1, `EMCS_IDX_CTRL, 32'h0, 4'h1);
    wb(1'b1, `EMCS_IDX_TXLN, 32'd2, 4'h3);
    go_wait();
    rc(`EMCS_IDX_STATUS, 32'h0, "abort cleared");
    $display("test transmit done");
    wb(1'b1, `EMCS_IDX_RXST, 32'h0100, 4'h3);
    stat = 32'h0;
    last_len = 32'h0;
    for (k = 0; k < 16; k++) begin
      filt = $random(seed) & 8'hef;
      ht = (k % 3 == 0) ? 32'h0 : 32'hffffffff;
      dst = dests[k % 4];
      fl = $random(seed);
      ctl = (k == 14) ? 8'h00 : (k == 15) ? 8'h44 : 8'h04;
      live = ctl == 8'h04;
      wb(1'b1, `EMCS_IDX_HTL, ht, 4'hf);
      wb(1'b1, `EMCS_IDX_HTH, ht, 4'hf);
      wb(1'b1, `EMCS_IDX_FILT, filt, 4'h1);
      wb(1'b1, `EMCS_IDX_CTRL, ctl, 4'h1);
      fr.delete();
      for (j = 5; j >= 0; j--) fr.push_back(dst[j*8 +: 8]);
      fr.push_back(8'h55);
      fr.push_back(k[7:0]);
      n0 = n_stored;
      fork
        u_peer.send_frame(fr, fl);
        begin
          repeat (4) @(posedge clk_sys);
          rc(`EMCS_IDX_STATUS, stat | (live << 2), "rx busy");
        end
      join
      repeat (3) @(posedge clk_sys);
      acc = live && accept(filt, dst, ht[0]);
      if (acc) last_len = 32'd8;
      if (live) stat = {fl[3:1], 3'b000};
      check("kept", n_stored - n0, acc);
      if (live)
        check("rx wr", {rx_dma_wr_addr, rx_dma_wr_data}, 32'h10700 | k);
      rc(`EMCS_IDX_RXLN, last_len, "rx length");
      rc(`EMCS_IDX_STATUS, stat, "rx errors");
    end
    $display("test receive done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
